// ==== logic/tcdma_pkg.sv ====
// Shared constants, types and helpers of the two-channel peripheral/RAM mover
package tcdma_pkg;

    localparam int NCH = 2;
    localparam int AW = 6;
    localparam int DW = 8;
    localparam int NSRC = 16;

    // Register offsets inside one channel window
    localparam logic [AW-1:0] CH_STRIDE = 6'h10;
    localparam logic [AW-1:0] OFS_SA = 6'h00;
    localparam logic [AW-1:0] OFS_RAL = 6'h01;
    localparam logic [AW-1:0] OFS_RAH = 6'h02;
    localparam logic [AW-1:0] OFS_CNTL = 6'h03;
    localparam logic [AW-1:0] OFS_CNTH = 6'h04;
    localparam logic [AW-1:0] OFS_MODE = 6'h05;
    localparam logic [AW-1:0] OFS_CTRL = 6'h06;

    // Shared registers
    localparam logic [AW-1:0] OFS_HOLD = 6'h20;
    localparam logic [AW-1:0] OFS_IRQ_STAT = 6'h21;
    localparam logic [AW-1:0] OFS_IRQ_MASK = 6'h22;

    // Field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_ST_BIT = 0;
    localparam int MODE_SWT_BIT = 7;
    localparam int MODE_DIR_BIT = 6;
    localparam int SRC_SEL_W = 4;

    // Reset values and count compare values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_LAST = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // Channel settings handed to an engine
    typedef struct packed {
        logic run;
        logic dir;
        logic [SRC_SEL_W-1:0] src_sel;
        logic [7:0] sa;
        logic [15:0] ra;
    } tcdma_cfg_t;

    // One access on the system memory bus
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } tcdma_bus_t;

    localparam tcdma_bus_t BUS_IDLE = '0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PEND = 3'b001,
        ST_RD = 3'b010,
        ST_CAP = 3'b011,
        ST_WR = 3'b100
    } tcdma_state_t;

    // Byte address of a channel register
    function automatic logic [AW-1:0] tcdma_reg_addr(input logic ch, input logic [AW-1:0] ofs);
        return ch ? AW'(CH_STRIDE + ofs) : ofs;
    endfunction : tcdma_reg_addr

endpackage : tcdma_pkg

// ==== logic/tcdma_rst_sync.sv ====
// Reset release synchroniser
module tcdma_rst_sync (
    input wire logic mclk,
    input wire logic rst_n,
    output logic rst_sync_n
);
    logic [1:0] sync_q;
    logic [1:0] sync_d;

    // Shift a one in after release
    always_comb begin
        sync_d = {sync_q[0], 1'b1};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 2'b00;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign rst_sync_n = sync_q[1];
endmodule : tcdma_rst_sync

// ==== logic/tcdma_chan.sv ====
// One channel's transfer engine: trigger latch, hold, read then write
module tcdma_chan #(
    parameter logic [7:0] SFR_PAGE = 8'hFF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input tcdma_pkg::tcdma_cfg_t cfg,
    input wire logic hold,
    input wire logic [tcdma_pkg::NSRC-1:0] trig_src,
    input wire logic sw_trig,
    input wire logic grant,
    input wire logic [7:0] mem_rdata,
    output logic want,
    output logic xfer,
    output logic busy,
    output logic step,
    output tcdma_pkg::tcdma_bus_t bus
);
    import tcdma_pkg::*;

    tcdma_state_t state_q, state_d;
    tcdma_bus_t bus_q, bus_d;
    logic pend_q, pend_d;
    logic trig;
    logic take;
    logic [15:0] sfr_addr;

    // Trigger latch, grant handshake and bus sequencing
    always_comb begin
        sfr_addr = {SFR_PAGE, cfg.sa};
        trig = sw_trig | trig_src[cfg.src_sel];
        take = (state_q == ST_PEND) && grant && !hold;
        pend_d = cfg.run & (trig | (pend_q & ~take));
        state_d = state_q;
        bus_d = BUS_IDLE;
        case (state_q)
            ST_IDLE: begin
                if (pend_q && cfg.run) begin
                    state_d = ST_PEND;
                end
            end
            ST_PEND: begin
                if (!cfg.run) begin
                    state_d = ST_IDLE;
                end else if (take) begin
                    state_d = ST_RD;
                    bus_d = '{req: 1'b1, we: 1'b0, addr: cfg.dir ? cfg.ra : sfr_addr, wdata: RST_BYTE};
                end
            end
            ST_RD: begin
                state_d = ST_CAP;
            end
            ST_CAP: begin
                state_d = ST_WR;
                bus_d = '{req: 1'b1, we: 1'b1, addr: cfg.dir ? sfr_addr : cfg.ra, wdata: mem_rdata};
            end
            ST_WR: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bus_q <= BUS_IDLE;
            pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bus_q <= bus_d;
            pend_q <= pend_d;
        end
    end

    // Status toward the controller
    assign want = (state_q == ST_PEND) && cfg.run && !hold;
    assign xfer = (state_q == ST_RD) || (state_q == ST_CAP) || (state_q == ST_WR);
    assign busy = (state_q != ST_IDLE);
    assign step = (state_q == ST_WR);
    assign bus = bus_q;
endmodule : tcdma_chan

// ==== logic/tcdma_top.sv ====
// Two-channel peripheral/RAM mover: registers, arbitration, interrupts
//
// Chosen here: the register offsets and the plain strobed port.

module tcdma_top #(
    parameter logic [7:0] SFR_PAGE = 8'hFF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [tcdma_pkg::AW-1:0] reg_addr,
    input wire logic [tcdma_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tcdma_pkg::DW-1:0] reg_rdata,
    input wire logic [tcdma_pkg::NSRC-1:0] periph_req,
    output tcdma_pkg::tcdma_bus_t mem_bus,
    input wire logic [7:0] mem_rdata,
    output logic chan0_done_irq,
    output logic chan1_done_irq,
    output logic dma_irq
);
    import tcdma_pkg::*;

    logic rst_sync_n;

    // Per-channel settings and state
    logic [7:0] sa_q [NCH];
    logic [7:0] sa_d [NCH];
    logic [15:0] ra_q [NCH];
    logic [15:0] ra_d [NCH];
    logic [15:0] cnt_q [NCH];
    logic [15:0] cnt_d [NCH];
    logic [7:0] mode_q [NCH];
    logic [7:0] mode_d [NCH];
    logic [NCH-1:0] en_q, en_d;
    logic [NCH-1:0] st_q, st_d;
    logic [NCH-1:0] stop_q, stop_d;
    logic [NCH-1:0] hold_q, hold_d;
    logic [NCH-1:0] stat_q, stat_d;
    logic [NCH-1:0] mask_q, mask_d;
    logic [NCH-1:0] done_q, done_d;
    logic [DW-1:0] rdata_q, rdata_d;

    // Engine links
    tcdma_cfg_t cfg [NCH];
    tcdma_bus_t cbus [NCH];
    logic [NCH-1:0] sw_trig;
    logic [NCH-1:0] want;
    logic [NCH-1:0] xfer;
    logic [NCH-1:0] busy;
    logic [NCH-1:0] step;
    logic [NCH-1:0] grant;

    tcdma_rst_sync u_rst (
        .mclk(mclk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // One engine per channel
    for (genvar g = 0; g < NCH; g++) begin : g_chan
        tcdma_chan #(
            .SFR_PAGE(SFR_PAGE)
        ) u_chan (
            .mclk(mclk),
            .rst_n(rst_sync_n),
            .cfg(cfg[g]),
            .hold(hold_q[g]),
            .trig_src(periph_req),
            .sw_trig(sw_trig[g]),
            .grant(grant[g]),
            .mem_rdata(mem_rdata),
            .want(want[g]),
            .xfer(xfer[g]),
            .busy(busy[g]),
            .step(step[g]),
            .bus(cbus[g])
        );
    end

    // Settings seen by the engines; a channel runs only while enabled and started
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cfg[i].run = en_q[i] & st_q[i] & ~stop_q[i] & (cnt_q[i] != CNT_ZERO);
            cfg[i].dir = mode_q[i][MODE_DIR_BIT];
            cfg[i].src_sel = mode_q[i][SRC_SEL_W-1:0];
            cfg[i].sa = sa_q[i];
            cfg[i].ra = ra_q[i];
        end
    end

    // Fixed priority, channel 0 first; a channel keeps the bus through its access
    always_comb begin
        grant[0] = want[0] & ~xfer[1];
        grant[1] = want[1] & ~want[0] & ~xfer[0];
    end

    // Only the engine in its access phase drives a non-idle request
    assign mem_bus = cbus[0] | cbus[1];

    // Register writes, unit steps, completion and stop handling
    always_comb begin
        logic [AW-1:0] a;
        a = reg_addr;
        en_d = en_q;
        st_d = st_q;
        stop_d = stop_q;
        hold_d = hold_q;
        mask_d = mask_q;
        done_d = '0;
        sw_trig = '0;
        for (int i = 0; i < NCH; i++) begin
            sa_d[i] = sa_q[i];
            ra_d[i] = ra_q[i];
            cnt_d[i] = cnt_q[i];
            mode_d[i] = mode_q[i];
            if (reg_wr) begin
                if (a == tcdma_reg_addr(1'(i), OFS_SA)) begin
                    sa_d[i] = reg_wdata;
                end
                if (a == tcdma_reg_addr(1'(i), OFS_RAL)) begin
                    ra_d[i][7:0] = reg_wdata;
                end
                if (a == tcdma_reg_addr(1'(i), OFS_RAH)) begin
                    ra_d[i][15:8] = reg_wdata;
                end
                if (a == tcdma_reg_addr(1'(i), OFS_CNTL)) begin
                    cnt_d[i][7:0] = reg_wdata;
                end
                if (a == tcdma_reg_addr(1'(i), OFS_CNTH)) begin
                    cnt_d[i][15:8] = reg_wdata;
                end
                if (a == tcdma_reg_addr(1'(i), OFS_MODE)) begin
                    mode_d[i] = reg_wdata;
                    mode_d[i][MODE_SWT_BIT] = 1'b0;
                    sw_trig[i] = reg_wdata[MODE_SWT_BIT];
                end
                if (a == tcdma_reg_addr(1'(i), OFS_CTRL)) begin
                    if (!st_q[i]) begin
                        en_d[i] = reg_wdata[CTRL_EN_BIT];
                        st_d[i] = reg_wdata[CTRL_ST_BIT] & reg_wdata[CTRL_EN_BIT];
                    end else if (!reg_wdata[CTRL_ST_BIT]) begin
                        stop_d[i] = 1'b1;
                    end
                end
            end
            // Unit moved: advance RAM address, count down, finish at zero
            if (step[i]) begin
                ra_d[i] = ra_q[i] + 16'h0001;
                cnt_d[i] = cnt_q[i] - 16'h0001;
                if (cnt_q[i] == CNT_LAST) begin
                    st_d[i] = 1'b0;
                    stop_d[i] = 1'b0;
                    done_d[i] = 1'b1;
                end
            end
            // Start/wait reads zero only once the engine is really idle
            if (stop_q[i] && !busy[i]) begin
                st_d[i] = 1'b0;
                stop_d[i] = 1'b0;
            end
        end
        if (reg_wr && a == OFS_HOLD) begin
            hold_d = reg_wdata[NCH-1:0];
        end
        if (reg_wr && a == OFS_IRQ_MASK) begin
            mask_d = reg_wdata[NCH-1:0];
        end
    end

    // Sticky done flags; a new completion wins over a write-one clear
    always_comb begin
        stat_d = stat_q;
        if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
            stat_d = stat_q & ~reg_wdata[NCH-1:0];
        end
        stat_d = stat_d | done_d;
    end

    // Read data, presented one cycle after the strobe
    always_comb begin
        rdata_d = RST_BYTE;
        if (reg_rd) begin
            for (int i = 0; i < NCH; i++) begin
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_SA)) begin
                    rdata_d = sa_q[i];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_RAL)) begin
                    rdata_d = ra_q[i][7:0];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_RAH)) begin
                    rdata_d = ra_q[i][15:8];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_CNTL)) begin
                    rdata_d = cnt_q[i][7:0];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_CNTH)) begin
                    rdata_d = cnt_q[i][15:8];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_MODE)) begin
                    rdata_d = mode_q[i];
                end
                if (reg_addr == tcdma_reg_addr(1'(i), OFS_CTRL)) begin
                    rdata_d[CTRL_EN_BIT] = en_q[i];
                    rdata_d[CTRL_ST_BIT] = st_q[i];
                end
            end
            if (reg_addr == OFS_HOLD) begin
                rdata_d[NCH-1:0] = hold_q;
            end
            if (reg_addr == OFS_IRQ_STAT) begin
                rdata_d[NCH-1:0] = stat_q;
            end
            if (reg_addr == OFS_IRQ_MASK) begin
                rdata_d[NCH-1:0] = mask_q;
            end
        end
    end

    // All settings clear on reset
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < NCH; i++) begin
                sa_q[i] <= RST_BYTE;
                ra_q[i] <= RST_WORD;
                cnt_q[i] <= RST_WORD;
                mode_q[i] <= RST_BYTE;
            end
            en_q <= '0;
            st_q <= '0;
            stop_q <= '0;
            hold_q <= '0;
            stat_q <= '0;
            mask_q <= '0;
            done_q <= '0;
            rdata_q <= RST_BYTE;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                sa_q[i] <= sa_d[i];
                ra_q[i] <= ra_d[i];
                cnt_q[i] <= cnt_d[i];
                mode_q[i] <= mode_d[i];
            end
            en_q <= en_d;
            st_q <= st_d;
            stop_q <= stop_d;
            hold_q <= hold_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign chan0_done_irq = done_q[0];
    assign chan1_done_irq = done_q[1];
    assign dma_irq = |(stat_q & mask_q);
endmodule : tcdma_top

// ==== verification/tcdma_chk.sv ====
// Concurrent checks on the ports of the two-channel peripheral/RAM mover
module tcdma_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [tcdma_pkg::AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tcdma_pkg::DW-1:0] reg_rdata,
    input wire logic [tcdma_pkg::NSRC-1:0] periph_req,
    input tcdma_pkg::tcdma_bus_t mem_bus,
    input wire logic [7:0] mem_rdata,
    input wire logic chan0_done_irq,
    input wire logic chan1_done_irq,
    input wire logic dma_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcdma_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic rd_q;
    logic [7:0] cap_q;

    // Keep the byte returned in the cycle after each memory read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            cap_q <= 8'h00;
        end else begin
            rd_q <= mem_bus.req && !mem_bus.we;
            cap_q <= rd_q ? mem_rdata : cap_q;
        end
    end

    a_read_then_write: assert property (mem_bus.req && !mem_bus.we |-> ##[2:3] (mem_bus.req && mem_bus.we))
        else $error("memory read not followed by its write");
    a_bus_owned: assert property (mem_bus.req && !mem_bus.we |=> !mem_bus.req)
        else $error("second access inside a read/write pair");
    a_write_data: assert property (mem_bus.req && mem_bus.we |-> mem_bus.wdata == cap_q)
        else $error("written byte differs from byte read");
    a_write_cause: assert property (mem_bus.req && mem_bus.we |-> $past(rd_q) || $past(rd_q, 2))
        else $error("write without a preceding read");
    a_done_after_write: assert property (chan0_done_irq || chan1_done_irq |-> $past(mem_bus.req && mem_bus.we))
        else $error("done pulse without a final write");
    a_done_pulse: assert property (chan0_done_irq |=> !chan0_done_irq)
        else $error("channel 0 done longer than one cycle");
    a_done_apart: assert property (!(chan0_done_irq && chan1_done_irq))
        else $error("both channels done in one cycle");
    a_irq_rise: assert property ($rose(dma_irq) |-> chan0_done_irq || chan1_done_irq
            || $past(chan0_done_irq || chan1_done_irq) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt rose without a cause");
    a_irq_fall: assert property ($fell(dma_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt fell without a clearing write");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    // Main scenarios reached
    c_done0: cover property (chan0_done_irq);
    c_done1: cover property (chan1_done_irq);
    c_irq: cover property ($rose(dma_irq));
endmodule : tcdma_chk

// ==== verification/tcdma_mem_model.sv ====
// Behavioural memory and peripheral space answering the mover's bus
module tcdma_mem_model (
    input wire logic mclk,
    input tcdma_pkg::tcdma_bus_t mem_bus,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcdma_pkg::*;

    logic [7:0] mem [0:65535];
    logic [7:0] data_q = 8'h00;
    logic valid_q = 1'b0;

    // Each byte starts as low address byte XOR high address byte
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8);
        end
    end

    // One-cycle read latency, writes stored at once
    always @(posedge mclk) begin
        valid_q <= mem_bus.req && !mem_bus.we;
        if (mem_bus.req && !mem_bus.we) begin
            data_q <= mem[mem_bus.addr];
        end
        if (mem_bus.req && mem_bus.we) begin
            mem[mem_bus.addr] <= mem_bus.wdata;
        end
    end

    // Data valid only in the answer cycle; the inverse elsewhere exposes late sampling
    assign mem_rdata = valid_q ? data_q : ~data_q;
endmodule : tcdma_mem_model

// ==== verification/tcdma_top_tb.sv ====
// Self-checking testbench of the two-channel peripheral/RAM mover
module tcdma_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcdma_pkg::*;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DW-1:0] reg_rdata;
    logic [NSRC-1:0] periph_req = '0;
    tcdma_bus_t mem_bus;
    logic [7:0] mem_rdata;
    logic chan0_done_irq;
    logic chan1_done_irq;
    logic dma_irq;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int n_req = 0;
    int n_done0 = 0;
    int n_done1 = 0;
    int k;
    logic [7:0] got;

    tcdma_top u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .mem_bus(mem_bus),
        .mem_rdata(mem_rdata), .chan0_done_irq(chan0_done_irq), .chan1_done_irq(chan1_done_irq),
        .dma_irq(dma_irq));
    tcdma_mem_model u_mem (.mclk(mclk), .mem_bus(mem_bus), .mem_rdata(mem_rdata));

    // Clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Count bus accesses, done pulses and cycles; cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (mem_bus.req === 1'b1) n_req++;
        if (chan0_done_irq === 1'b1) n_done0++;
        if (chan1_done_irq === 1'b1) n_done1++;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [AW-1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check($sformatf("reg %h", a), exp, d);
    endtask : rdc

    // One high cycle on a start source, then room for the whole transfer
    task automatic trig(input int b);
        @(posedge mclk);
        periph_req[b] <= 1'b1;
        @(posedge mclk);
        periph_req[b] <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask : trig

    // Enable first, then the settings, then start/wait
    task automatic prog(input logic ch, input logic [7:0] sa, input logic [15:0] ra, input logic [15:0] cnt,
            input logic [7:0] mode);
        logic [AW-1:0] b;
        b = ch ? CH_STRIDE : '0;
        wr(AW'(b + OFS_CTRL), 8'h80);
        wr(AW'(b + OFS_SA), sa);
        wr(AW'(b + OFS_RAL), ra[7:0]);
        wr(AW'(b + OFS_RAH), ra[15:8]);
        wr(AW'(b + OFS_CNTL), cnt[7:0]);
        wr(AW'(b + OFS_CNTH), cnt[15:8]);
        wr(AW'(b + OFS_MODE), mode);
        wr(AW'(b + OFS_CTRL), 8'h81);
    endtask : prog

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int a = 0; a < 7; a++) begin
            rdc(AW'(a), 8'h00);
            rdc(AW'(CH_STRIDE + AW'(a)), 8'h00);
        end
        rdc(OFS_HOLD, 8'h00);
        rdc(OFS_IRQ_STAT, 8'h00);
        rdc(OFS_IRQ_MASK, 8'h00);
        rdc(6'h3F, 8'h00);
        $display("test reset values done");
        // Channel 0, peripheral to RAM, three units on start source 2
        prog(1'b0, 8'h10, 16'h0100, 16'h0003, 8'h02);
        wr(OFS_CTRL, 8'h01);
        rdc(OFS_CTRL, 8'h81);
        repeat (3) trig(2);
        for (int i = 0; i < 3; i++) begin
            check("ram byte", 8'hEF, u_mem.mem[16'h0100 + i]);
        end
        rdc(OFS_CNTL, 8'h00);
        rdc(OFS_CNTH, 8'h00);
        rdc(OFS_RAL, 8'h03);
        rdc(OFS_RAH, 8'h01);
        rdc(OFS_CTRL, 8'h80);
        check("done0 pulses", 8'h01, 8'(n_done0));
        rdc(OFS_IRQ_STAT, 8'h01);
        check("irq masked", 8'h00, 8'(dma_irq));
        wr(OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge mclk);
        check("irq unmasked", 8'h01, 8'(dma_irq));
        wr(OFS_IRQ_STAT, 8'h01);
        repeat (2) @(posedge mclk);
        check("irq cleared", 8'h00, 8'(dma_irq));
        $display("test channel 0 peripheral to RAM done");
        // Channel 1, RAM to peripheral, two software triggers
        prog(1'b1, 8'h20, 16'h0200, 16'h0002, 8'h40);
        for (int i = 0; i < 2; i++) begin
            wr(AW'(CH_STRIDE + OFS_MODE), 8'hC0);
            repeat (10) @(posedge mclk);
        end
        check("periph byte", 8'h03, u_mem.mem[16'hFF20]);
        check("done1 pulses", 8'h01, 8'(n_done1));
        rdc(OFS_IRQ_STAT, 8'h02);
        check("irq other mask", 8'h00, 8'(dma_irq));
        rdc(AW'(CH_STRIDE + OFS_CTRL), 8'h80);
        rdc(AW'(CH_STRIDE + OFS_MODE), 8'h40);
        $display("test channel 1 software trigger done");
        // Hold, release, forced stop
        prog(1'b0, 8'h10, 16'h0110, 16'h0002, 8'h02);
        wr(OFS_HOLD, 8'h01);
        k = n_req;
        trig(2);
        check("held requests", 8'(k), 8'(n_req));
        rdc(OFS_CNTL, 8'h02);
        wr(OFS_HOLD, 8'h00);
        repeat (10) @(posedge mclk);
        rdc(OFS_CNTL, 8'h01);
        wr(OFS_CTRL, 8'h80);
        got = 8'h81;
        for (int i = 0; i < 8 && got !== 8'h80; i++) begin
            rd(OFS_CTRL, got);
        end
        check("stop poll", 8'h80, got);
        wr(OFS_CTRL, 8'h00);
        rdc(OFS_CTRL, 8'h00);
        trig(2);
        rdc(OFS_CNTL, 8'h01);
        $display("test hold and forced stop done");
        // Serial reception: channel 0 takes received bytes on source 4, channel 1 sends dummies on source 3
        prog(1'b0, 8'h31, 16'h0300, 16'h0002, 8'h04);
        prog(1'b1, 8'h30, 16'h0310, 16'h0001, 8'h43);
        // First dummy went out by software, so first receive and buffer-empty arrive together
        @(posedge mclk);
        periph_req <= 16'h0018;
        @(posedge mclk);
        periph_req <= 16'h0000;
        repeat (16) @(posedge mclk);
        check("dummy byte", 8'h13, u_mem.mem[16'hFF30]);
        check("tx done", 8'h02, 8'(n_done1));
        check("rx pending", 8'h01, 8'(n_done0));
        trig(4);
        check("rx done", 8'h02, 8'(n_done0));
        check("first rx", 8'hCE, u_mem.mem[16'h0300]);
        rdc(OFS_RAL, 8'h02);
        $display("test serial reception done");
        // Re-arm both only after the serial transfer has ended, then stop both under hold
        wr(OFS_CNTL, 8'h01);
        wr(OFS_CTRL, 8'h81);
        wr(AW'(CH_STRIDE + OFS_CNTL), 8'h01);
        wr(AW'(CH_STRIDE + OFS_CTRL), 8'h81);
        wr(OFS_HOLD, 8'h03);
        k = n_req;
        @(posedge mclk);
        periph_req <= 16'h0018;
        @(posedge mclk);
        periph_req <= 16'h0000;
        repeat (4) @(posedge mclk);
        wr(OFS_CTRL, 8'h80);
        wr(AW'(CH_STRIDE + OFS_CTRL), 8'h80);
        rdc(OFS_CTRL, 8'h80);
        rdc(AW'(CH_STRIDE + OFS_CTRL), 8'h80);
        wr(OFS_HOLD, 8'h00);
        wr(OFS_CTRL, 8'h00);
        wr(AW'(CH_STRIDE + OFS_CTRL), 8'h00);
        rdc(OFS_CTRL, 8'h00);
        rdc(AW'(CH_STRIDE + OFS_CTRL), 8'h00);
        check("dual stop requests", 8'(k), 8'(n_req));
        rdc(OFS_CNTL, 8'h01);
        rdc(AW'(CH_STRIDE + OFS_CNTL), 8'h01);
        // Single-channel stop without polling: clear enable four clocks after start/wait
        prog(1'b0, 8'h10, 16'h0120, 16'h0001, 8'h02);
        wr(OFS_CTRL, 8'h80);
        repeat (2) @(posedge mclk);
        wr(OFS_CTRL, 8'h00);
        rdc(OFS_CTRL, 8'h00);
        $display("test dual stop and timed stop done");
        conclude();
    end
endmodule : tcdma_top_tb

bind tcdma_top tcdma_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .mem_bus(mem_bus),
    .mem_rdata(mem_rdata), .chan0_done_irq(chan0_done_irq), .chan1_done_irq(chan1_done_irq), .dma_irq(dma_irq));
